/* File: rtl/awu_top.sv */
// Behaviour
// - Oscillator runs while any control register enable bit set.
// - Reset enable, once set, cannot be undone.
// - Timeout with reset enable resets the system.
// - Watchdog reset suspended in stop mode.
// - Restart bit restarts period, reads zero.
// - Reset output driven only in run mode.
// - Reset enable written once after reset.
// - Periodic wake from stop on each timeout.
// - Wake line only in stop with enable.
// - Cyclic Hall sampling wakes on high input.
// - Cyclic check enable gates Hall/analog checks.
// - Timeout flag set; write one clears, restarts.
// - Rate bit picks 10 ms or 20 ms.
// - Reset clears control register, top bits zero.
// - Stop bit enters stop; cleared by interrupt.
`timescale 1ns/100ps
`default_nettype none
module awu_top #(
	parameter int FAST_CYCLES = awu_pkg::FAST_CYCLES,
	parameter int SLOW_CYCLES = awu_pkg::SLOW_CYCLES
) (
	input wire logic CLOCK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic [2:0] HALL_IN,
	input wire logic CPU_IRQ_REQ_IN,
	output logic WDOG_RESET_OUT,
	output logic WAKE_IRQ_OUT,
	output logic [2:0] HALL_POWER_OUT,
	output logic ANALOG_POWER_OUT,
	output logic REGULATOR_ON_OUT,
	output logic STOP_MODE_OUT,
	output logic OSC_RUN_OUT,
	output logic IRQ_OUT
);
	localparam int SAMPLE_W = $clog2(awu_pkg::SAMPLE_CYCLES + 1);
	localparam logic [SAMPLE_W-1:0] SAMPLE_LAST = SAMPLE_W'(awu_pkg::SAMPLE_CYCLES - 1);

	logic reset_enable;
	logic re_locked;
	logic irq_enable;
	logic cc_enable;
	logic rate_fast;
	logic timeout_flag;
	logic stop_mode;
	logic [awu_pkg::HALL_WIDTH-1:0] hall_select;
	logic hall_irq_enable;
	logic hall_wake;
	logic [awu_pkg::EV_WIDTH-1:0] irq_status;
	logic [awu_pkg::EV_WIDTH-1:0] irq_mask;
	logic [awu_pkg::EV_WIDTH-1:0] events;
	logic [SAMPLE_W-1:0] sample_count;
	awu_pkg::awu_check_type check_state;
	awu_pkg::awu_check_type next_check_state;
	logic osc_run;
	logic restart;
	logic timeout;
	logic hall_hit;
	logic bus_write;
	logic bus_setup;
	logic hit;
	logic wr_ctrl;
	logic wr_stop;
	logic wr_hall;
	logic wr_clear;
	logic wr_mask;
	logic [31:0] next_prdata;
	logic [7:0] ctrl_read;

	// The slave never stalls, so every access completes in its first access cycle.
	assign PREADY_OUT = 1'b1;
	assign bus_write = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign bus_setup = PSEL_IN && !PENABLE_IN;
	assign hit = (PADDR_IN == awu_pkg::ADDR_CTRL) || (PADDR_IN == awu_pkg::ADDR_STOP)
		|| (PADDR_IN == awu_pkg::ADDR_HALL_CFG) || (PADDR_IN == awu_pkg::ADDR_IRQ_STATUS)
		|| (PADDR_IN == awu_pkg::ADDR_IRQ_CLEAR) || (PADDR_IN == awu_pkg::ADDR_IRQ_ENABLE);
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;
	assign wr_ctrl = bus_write && (PADDR_IN == awu_pkg::ADDR_CTRL);
	assign wr_stop = bus_write && (PADDR_IN == awu_pkg::ADDR_STOP);
	assign wr_hall = bus_write && (PADDR_IN == awu_pkg::ADDR_HALL_CFG);
	assign wr_clear = bus_write && (PADDR_IN == awu_pkg::ADDR_IRQ_CLEAR);
	assign wr_mask = bus_write && (PADDR_IN == awu_pkg::ADDR_IRQ_ENABLE);

	assign osc_run = reset_enable || irq_enable || cc_enable;
	assign OSC_RUN_OUT = osc_run;
	assign restart = wr_ctrl && (PWDATA_IN[awu_pkg::RESTART_BIT] || PWDATA_IN[awu_pkg::FLAG_BIT]);

	awu_timebase #(
		.FAST_CYCLES(FAST_CYCLES),
		.SLOW_CYCLES(SLOW_CYCLES)
	) timebase (
		.clock_in(CLOCK_IN),
		.rstn_in(RSTN_IN),
		.run_in(osc_run),
		.restart_in(restart),
		.fast_in(rate_fast),
		.timeout_out(timeout)
	);

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			reset_enable <= 1'b0;
			re_locked <= 1'b0;
		end
		else if (wr_ctrl && !re_locked)
		begin
			reset_enable <= PWDATA_IN[awu_pkg::RE_BIT];
			re_locked <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			irq_enable <= 1'b0;
			cc_enable <= 1'b0;
			rate_fast <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			irq_enable <= PWDATA_IN[awu_pkg::IE_BIT];
			cc_enable <= PWDATA_IN[awu_pkg::CC_BIT];
			rate_fast <= PWDATA_IN[awu_pkg::RATE_BIT];
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			timeout_flag <= 1'b0;
		else if (timeout)
			timeout_flag <= 1'b1;
		else if (wr_ctrl && PWDATA_IN[awu_pkg::FLAG_BIT])
			timeout_flag <= 1'b0;
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			stop_mode <= 1'b0;
		else if (wr_stop && PWDATA_IN[awu_pkg::STOP_BIT])
			stop_mode <= 1'b1;
		else if (CPU_IRQ_REQ_IN)
			stop_mode <= 1'b0;
	end
	assign STOP_MODE_OUT = stop_mode;

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			hall_select <= '0;
			hall_irq_enable <= 1'b0;
		end
		else if (wr_hall)
		begin
			hall_select <= PWDATA_IN[awu_pkg::HALL_WIDTH-1:0];
			hall_irq_enable <= PWDATA_IN[awu_pkg::HALL_IE_BIT];
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			WDOG_RESET_OUT <= 1'b0;
		else
			WDOG_RESET_OUT <= timeout && reset_enable && !stop_mode;
	end

	always_comb
	begin
		next_check_state = check_state;
		case (check_state)
			awu_pkg::CHK_IDLE:
				if (timeout && stop_mode && cc_enable)
					next_check_state = awu_pkg::CHK_POWER;
			awu_pkg::CHK_POWER:
				if (!stop_mode || !cc_enable)
					next_check_state = awu_pkg::CHK_IDLE;
				else if (sample_count == SAMPLE_LAST)
					next_check_state = awu_pkg::CHK_DECIDE;
			awu_pkg::CHK_DECIDE:
				next_check_state = awu_pkg::CHK_IDLE;
			default:
				next_check_state = awu_pkg::CHK_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			check_state <= awu_pkg::CHK_IDLE;
		else
			check_state <= next_check_state;
	end

	// The sensors need a settling window after power-up before their level means anything.
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			sample_count <= '0;
		else if (check_state == awu_pkg::CHK_POWER)
			sample_count <= sample_count + SAMPLE_W'(1);
		else
			sample_count <= '0;
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			HALL_POWER_OUT <= '0;
			ANALOG_POWER_OUT <= 1'b0;
		end
		else if (next_check_state != awu_pkg::CHK_IDLE)
		begin
			HALL_POWER_OUT <= hall_select;
			ANALOG_POWER_OUT <= 1'b1;
		end
		else
		begin
			HALL_POWER_OUT <= '0;
			ANALOG_POWER_OUT <= 1'b0;
		end
	end

	assign hall_hit = (check_state == awu_pkg::CHK_DECIDE) && stop_mode
		&& hall_irq_enable && |(HALL_IN & hall_select);

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			hall_wake <= 1'b0;
		else if (hall_hit)
			hall_wake <= 1'b1;
		else if (!stop_mode)
			hall_wake <= 1'b0;
	end

	// The main regulator is always on in run mode; in stop only a Hall wake turns it on.
	assign REGULATOR_ON_OUT = !stop_mode || hall_wake;
	assign WAKE_IRQ_OUT = stop_mode && ((timeout_flag && irq_enable) || hall_wake);

	assign events = {WDOG_RESET_OUT, hall_hit, timeout};

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			irq_status <= '0;
		else if (wr_clear)
			irq_status <= events | (irq_status & ~PWDATA_IN[awu_pkg::EV_WIDTH-1:0]);
		else
			irq_status <= irq_status | events;
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			irq_mask <= '0;
		else if (wr_mask)
			irq_mask <= PWDATA_IN[awu_pkg::EV_WIDTH-1:0];
	end

	assign IRQ_OUT = |(irq_status & irq_mask);

	assign ctrl_read = {3'h0, reset_enable, irq_enable, cc_enable, timeout_flag, rate_fast};

	always_comb
	begin
		next_prdata = 32'h0;
		case (PADDR_IN)
			awu_pkg::ADDR_CTRL:
				next_prdata[7:0] = ctrl_read;
			awu_pkg::ADDR_HALL_CFG:
				next_prdata[awu_pkg::HALL_IE_BIT:0] = {hall_irq_enable, hall_select};
			awu_pkg::ADDR_IRQ_STATUS:
				next_prdata[awu_pkg::EV_WIDTH-1:0] = irq_status;
			awu_pkg::ADDR_IRQ_ENABLE:
				next_prdata[awu_pkg::EV_WIDTH-1:0] = irq_mask;
			default:
				next_prdata = 32'h0;
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flip-flop at the access edge.
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			PRDATA_OUT <= 32'h0;
		else if (bus_setup && !PWRITE_IN)
			PRDATA_OUT <= next_prdata;
	end

	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RSTN_IN);

	sequence s_ctrl_write;
		wr_ctrl;
	endsequence

	sequence s_hall_hit;
		hall_hit && !CPU_IRQ_REQ_IN;
	endsequence

	a_osc_off_quiet: assert property (!osc_run ##1 !osc_run |-> !timeout)
		else $error("Timeout seen while oscillator is off.");
	a_re_sticky: assert property (reset_enable |=> reset_enable)
		else $error("Reset enable was cleared.");
	a_reset_fires: assert property (timeout && reset_enable && !stop_mode |=> WDOG_RESET_OUT)
		else $error("Timeout with reset enable gave no reset.");
	a_reset_run_only: assert property (WDOG_RESET_OUT |-> !$past(stop_mode))
		else $error("Watchdog reset raised from stop mode.");
	a_restart_period: assert property (s_ctrl_write ##0 PWDATA_IN[awu_pkg::RESTART_BIT]
		|=> !timeout ##1 !timeout)
		else $error("Timeout right after a restart.");
	a_re_write_once: assert property ((re_locked and s_ctrl_write) |=> $stable(reset_enable))
		else $error("Reset enable changed on a second write.");
	a_irq_stop_only: assert property (WAKE_IRQ_OUT |-> stop_mode)
		else $error("Wake line asserted in run mode.");
	a_periodic_wake: assert property (timeout && stop_mode && irq_enable && !CPU_IRQ_REQ_IN
		&& !wr_ctrl |=> WAKE_IRQ_OUT)
		else $error("Timeout in stop did not raise wake line.");
	a_hall_wakes: assert property (s_hall_hit |=> REGULATOR_ON_OUT && WAKE_IRQ_OUT)
		else $error("Hall hit did not wake the system.");
	a_check_gated: assert property (check_state != awu_pkg::CHK_IDLE |-> $past(cc_enable))
		else $error("Cyclic check ran while disabled.");
	a_flag_sets: assert property (timeout |=> timeout_flag)
		else $error("Timeout did not set the flag.");
	a_ctrl_top_zero: assert property (bus_setup && !PWRITE_IN && PADDR_IN == awu_pkg::ADDR_CTRL
		|=> PRDATA_OUT[7:5] == 3'h0)
		else $error("Control read shows upper bits set.");
	a_stop_enter: assert property (wr_stop && PWDATA_IN[awu_pkg::STOP_BIT] |=> stop_mode)
		else $error("Stop request did not enter stop mode.");

endmodule
`default_nettype wire

/* File: rtl/awu_pkg.sv */
package awu_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam int CTRL_INDEX = 'h0a;
	localparam int STOP_INDEX = 'h03;
	localparam logic [11:0] ADDR_CTRL = 12'(4 * CTRL_INDEX);
	localparam logic [11:0] ADDR_STOP = 12'(4 * STOP_INDEX);
	localparam logic [11:0] ADDR_HALL_CFG = 12'h030;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h040;
	localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h044;
	localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h048;

	// Control register fields.
	localparam int RATE_BIT = 0;
	localparam int FLAG_BIT = 1;
	localparam int CC_BIT = 2;
	localparam int IE_BIT = 3;
	localparam int RE_BIT = 4;
	localparam int RESTART_BIT = 5;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Stop register and Hall configuration fields.
	localparam int STOP_BIT = 0;
	localparam int HALL_WIDTH = 3;
	localparam int HALL_IE_BIT = 3;

	// Interrupt status layout.
	localparam int EV_TIMEOUT = 0;
	localparam int EV_WAKE = 1;
	localparam int EV_RESET = 2;
	localparam int EV_WIDTH = 3;

	// Timing.
	localparam int CLOCK_KHZ = 125000;
	localparam int FAST_PERIOD_MS = 10;
	localparam int SLOW_PERIOD_MS = 20;
	localparam int FAST_CYCLES = FAST_PERIOD_MS * CLOCK_KHZ;
	localparam int SLOW_CYCLES = SLOW_PERIOD_MS * CLOCK_KHZ;
	localparam int SAMPLE_TIME_NS = 1000;
	localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS * CLOCK_KHZ + 999999) / 1000000;

	typedef enum logic [2:0] {
		CHK_IDLE = 3'b001,
		CHK_POWER = 3'b010,
		CHK_DECIDE = 3'b100
	} awu_check_type;

endpackage

/* File: rtl/awu_timebase.sv */
`timescale 1ns/100ps
`default_nettype none
module awu_timebase #(
	parameter int FAST_CYCLES = 1250000,
	parameter int SLOW_CYCLES = 2500000
) (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic run_in,
	input wire logic restart_in,
	input wire logic fast_in,
	output logic timeout_out
);
	localparam int W = $clog2(SLOW_CYCLES + 1);
	localparam logic [W-1:0] FAST_END = W'(FAST_CYCLES - 1);
	localparam logic [W-1:0] SLOW_END = W'(SLOW_CYCLES - 1);

	logic [W-1:0] count;
	logic [W-1:0] end_value;
	logic at_end;

	assign end_value = fast_in ? FAST_END : SLOW_END;
	// A rate change below the running count ends the period at once rather than wrapping.
	assign at_end = (count >= end_value);

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			count <= '0;
		else if (!run_in || restart_in || at_end)
			count <= '0;
		else
			count <= count + W'(1);
	end

	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
			timeout_out <= 1'b0;
		else
			timeout_out <= run_in && !restart_in && at_end;
	end

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);

	a_count_held: assert property (!run_in |=> count == '0)
		else $error("Timeout counter moved while stopped.");
	a_count_bound: assert property (count <= SLOW_END)
		else $error("Timeout counter passed the slow end value.");

endmodule
`default_nettype wire

/* File: verification/awu_mcu_model.sv */
`timescale 1ns/100ps
`default_nettype none
module awu_mcu_model (
	input wire logic clock_in,
	input wire logic rstn_in,
	input wire logic wake_in,
	input wire logic [3:0] lag_in,
	output logic irq_req_out
);
	logic [3:0] wait_count;
	// The core needs lag_in cycles to wake before it can take the interrupt.
	// interrupt ends stop
	always_ff @(posedge clock_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			wait_count <= 4'h0;
			irq_req_out <= 1'b0;
		end
		else
		begin
			irq_req_out <= 1'b0;
			if (!wake_in)
				wait_count <= 4'h0;
			else if (wait_count < lag_in)
				wait_count <= wait_count + 4'h1;
			else if (!irq_req_out)
				irq_req_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
	localparam int FAST = 20;
	localparam int SLOW = 40;
	typedef struct {
		logic [11:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic e;
		logic o;
	} awu_row_type;
	awu_row_type rows [6];
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pd = 32'h0;
	logic [2:0] hall = 3'h0;
	logic [3:0] lag = 4'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, perr, err, cpu_irq, wdog, wake, reg_on, stop, osc, irq, apow;
	logic [2:0] hpow;
	int fail_count = 0;
	int total_checks = 0;
	int wdog_seen = 0;
	int n;
	wire logic [4:0] obs = {|hpow, irq, stop, wake, wdog};
	awu_top #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) u_awu_top (.CLOCK_IN(clk),
		.RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(pa), .PWDATA_IN(pd), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(perr), .HALL_IN(hall), .CPU_IRQ_REQ_IN(cpu_irq),
		.WDOG_RESET_OUT(wdog), .WAKE_IRQ_OUT(wake), .HALL_POWER_OUT(hpow),
		.ANALOG_POWER_OUT(apow), .REGULATOR_ON_OUT(reg_on), .STOP_MODE_OUT(stop),
		.OSC_RUN_OUT(osc), .IRQ_OUT(irq));
	awu_mcu_model u_awu_mcu_model (.clock_in(clk), .rstn_in(rstn), .wake_in(wake),
		.lag_in(lag), .irq_req_out(cpu_irq));
	initial
	begin
		forever #4 clk = ~clk;
	end
	always @(negedge clk)
		if (wdog === 1'b1)
			wdog_seen++;
	task tally_and_finish;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task do_reset;
		@(posedge clk);
		rstn <= 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
	endtask
	// Ends on the falling edge so that callers see settled outputs.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1'b1;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (pready !== 1'b1 && i < 16);
		`CHK(pready, 1'b1)
		if (pready !== 1'b1)
			tally_and_finish();
		rd = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(negedge clk);
	endtask
	task waitv(input int k, input logic v, input int lim);
		n = 0;
		while (obs[k] !== v && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		if (obs[k] !== v)
		begin
			`CHK(obs[k], v)
			tally_and_finish();
		end
	endtask
	initial
	begin
		rows = '{'{awu_pkg::ADDR_CTRL, 32'h29, 32'h09, 1'b0, 1'b1},
			'{awu_pkg::ADDR_CTRL, 32'h14, 32'h04, 1'b0, 1'b1},
			'{awu_pkg::ADDR_CTRL, 32'h00, 32'h00, 1'b0, 1'b0},
			'{12'hffc, 32'hff, 32'h00, 1'b1, 1'b0},
			'{awu_pkg::ADDR_HALL_CFG, 32'h0b, 32'h0b, 1'b0, 1'b0},
			'{awu_pkg::ADDR_IRQ_ENABLE, 32'h07, 32'h07, 1'b0, 1'b0}};
		do_reset();
		@(negedge clk);
		`CHK({osc, irq, reg_on}, 3'b001)
		apb(1'b0, awu_pkg::ADDR_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		foreach (rows[i])
		begin
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			`CHK({err, rd, osc}, {rows[i].e, rows[i].q, rows[i].o})
		end
		for (int r = 1; r >= 0; r--)
		begin
			apb(1'b1, awu_pkg::ADDR_CTRL, 32'h08 | 32'(r));
			waitv(3, 1'b1, 60);
			`CHK(n >= (r ? FAST : SLOW) - 2 && n <= (r ? FAST : SLOW) + 3, 1'b1)
			`CHK(wake, 1'b0)
			apb(1'b0, awu_pkg::ADDR_CTRL, 32'h0);
			`CHK(rd, 32'h0a | 32'(r))
			apb(1'b1, awu_pkg::ADDR_IRQ_ENABLE, 32'h0);
			`CHK(irq, 1'b0)
			apb(1'b1, awu_pkg::ADDR_IRQ_ENABLE, 32'h7);
			`CHK(irq, 1'b1)
			apb(1'b1, awu_pkg::ADDR_IRQ_CLEAR, 32'h7);
			`CHK(irq, 1'b0)
			apb(1'b1, awu_pkg::ADDR_CTRL, 32'h02);
			apb(1'b0, awu_pkg::ADDR_CTRL, 32'h0);
			`CHK({osc, rd}, 33'h0)
		end
		do_reset();
		apb(1'b1, awu_pkg::ADDR_CTRL, 32'h10);
		repeat (4)
		begin
			repeat (30) @(negedge clk);
			apb(1'b1, awu_pkg::ADDR_CTRL, 32'h30);
		end
		`CHK(wdog_seen, 0)
		apb(1'b1, awu_pkg::ADDR_CTRL, 32'h00);
		apb(1'b0, awu_pkg::ADDR_CTRL, 32'h0);
		`CHK({osc, rd}, {1'b1, 32'h10})
		waitv(0, 1'b1, 60);
		@(negedge clk);
		`CHK(wdog, 1'b0)
		apb(1'b0, awu_pkg::ADDR_IRQ_STATUS, 32'h0);
		`CHK(rd[2], 1'b1)
		apb(1'b1, awu_pkg::ADDR_STOP, 32'h1);
		`CHK({stop, reg_on}, 2'b10)
		wdog_seen = 0;
		repeat (100) @(negedge clk);
		`CHK(wdog_seen, 0)
		apb(1'b1, awu_pkg::ADDR_CTRL, 32'h0b);
		waitv(1, 1'b1, 40);
		`CHK(n >= FAST - 3, 1'b1)
		waitv(2, 1'b0, 40);
		`CHK({wake, reg_on}, 2'b01)
		wdog_seen = 0;
		repeat (50) @(negedge clk);
		`CHK(wdog_seen > 0, 1'b1)
		do_reset();
		lag <= 4'h9;
		apb(1'b1, awu_pkg::ADDR_HALL_CFG, 32'h0b);
		apb(1'b1, awu_pkg::ADDR_CTRL, 32'h04);
		@(posedge clk);
		hall <= 3'b100;
		apb(1'b1, awu_pkg::ADDR_STOP, 32'h1);
		waitv(4, 1'b1, 60);
		`CHK({hpow, apow}, 4'b0111)
		waitv(4, 1'b0, 200);
		`CHK(wake, 1'b0)
		@(posedge clk);
		hall <= 3'b010;
		waitv(1, 1'b1, 300);
		`CHK(reg_on, 1'b1)
		waitv(2, 1'b0, 40);
		tally_and_finish();
	end
endmodule
`default_nettype wire
